/* ram_pkg.sv */
// constants, modes and carrier types of the configurable embedded ram
package ram_pkg;
   localparam int ROW_W    = 144;
   localparam int ROWS     = 4096;
   localparam int ROW_AW   = 12;
   localparam int ADDR_W   = 19;
   localparam int AXI_AW   = 8;
   localparam int CFG_W    = 16;
   localparam logic [12:0] ROWS_SMALL  = 13'h0004;
   localparam logic [12:0] ROWS_MEDIUM = 13'h0020;
   localparam logic [12:0] ROWS_LARGE  = 13'h1000;
   localparam logic [2:0]  K_MAX_SMALL  = 3'h4;
   localparam logic [2:0]  K_MAX_MEDIUM = 3'h5;
   localparam logic [2:0]  K_MIN_LARGE  = 3'h3;
   localparam logic [2:0]  K_MAX_LARGE  = 3'h7;
   localparam logic [2:0]  K_PAR_BASE   = 3'h3;
   localparam logic [2:0]  K_ROW_BITS   = 3'h7;
   localparam logic [11:0] HALF_MASK    = 12'h00F;
   localparam logic [11:0] HALF_BASE    = 12'h010;
   localparam logic [AXI_AW-1:0] CFG_OFF  = 8'h00;
   localparam logic [AXI_AW-1:0] STAT_OFF = 8'h04;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [ROW_W-1:0] RDW_UNKNOWN = {ROW_W{1'b1}};

   typedef enum logic [1:0] {
      MODE_TRUE_DUAL, MODE_SIMPLE_DUAL, MODE_SINGLE, MODE_TWO_SINGLE
   } mode_type;

   typedef enum logic [1:0] {
      CLASS_SMALL, CLASS_MEDIUM, CLASS_LARGE
   } class_type;

   typedef struct packed {
      logic [3:0] spare;
      logic       flow;
      logic       rdw_old;
      logic       oreg_b;
      logic       oreg_a;
      logic       par_b;
      logic       par_a;
      logic [2:0] wk_b;
      logic [2:0] wk_a;
      class_type  cls;
      mode_type   mode;
   } cfg_type;

   typedef struct packed {
      logic [9:0]  spare;
      logic [2:0]  wk_b;
      logic [2:0]  wk_a;
      logic [15:0] coll;
   } stat_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [ROW_W-1:0]  din;
      logic              we;
      logic              re;
   } port_req_type;

   localparam cfg_type CFG_RESET = '{spare: 4'h0, flow: 1'b0,
      rdw_old: 1'b1, oreg_b: 1'b1, oreg_a: 1'b1, par_b: 1'b0,
      par_a: 1'b0, wk_b: 3'h0, wk_a: 3'h0, cls: CLASS_MEDIUM,
      mode: MODE_TRUE_DUAL};
endpackage : ram_pkg

/* configurable_embedded_ram.sv */
// configurable embedded ram: two ports, three size classes, axi4-lite setup
`timescale 1ns/1ps
module configurable_embedded_ram
   import ram_pkg::*;
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic [1:0]               ce,
   input  wire port_req_type [1:0]       req,
   input  wire logic [1:0]               clr_in,
   input  wire logic [1:0]               clr_out,
   output logic [1:0][ROW_W-1:0]         q,
   input  wire logic [AXI_AW-1:0]        s_axi_awaddr,
   input  wire logic                     s_axi_awvalid,
   output logic                          s_axi_awready,
   input  wire logic [31:0]              s_axi_wdata,
   input  wire logic [3:0]               s_axi_wstrb,
   input  wire logic                     s_axi_wvalid,
   output logic                          s_axi_wready,
   output logic [1:0]                    s_axi_bresp,
   output logic                          s_axi_bvalid,
   input  wire logic                     s_axi_bready,
   input  wire logic [AXI_AW-1:0]        s_axi_araddr,
   input  wire logic                     s_axi_arvalid,
   output logic                          s_axi_arready,
   output logic [31:0]                   s_axi_rdata,
   output logic [1:0]                    s_axi_rresp,
   output logic                          s_axi_rvalid,
   input  wire logic                     s_axi_rready
);

   function automatic logic [12:0] rows_of(class_type c);
      unique case (c)
         CLASS_MEDIUM: rows_of = ROWS_MEDIUM;
         CLASS_LARGE:  rows_of = ROWS_LARGE;
         default:      rows_of = ROWS_SMALL;
      endcase
   endfunction : rows_of

   function automatic logic [2:0] clamp_k(class_type c, logic [2:0] k);
      unique case (c)
         CLASS_MEDIUM: clamp_k = (k > K_MAX_MEDIUM) ? K_MAX_MEDIUM : k;
         CLASS_LARGE:  clamp_k = (k < K_MIN_LARGE) ? K_MIN_LARGE : k;
         default:      clamp_k = (k > K_MAX_SMALL) ? K_MAX_SMALL : k;
      endcase
   endfunction : clamp_k

   function automatic logic [7:0] width_of(logic [2:0] k, logic par);
      if (par && k >= K_PAR_BASE)
         width_of = 8'(9 << (k - K_PAR_BASE));
      else
         width_of = 8'(1 << k);
   endfunction : width_of

   function automatic logic [ROW_W-1:0] low_mask(logic [7:0] w);
      low_mask = (ROW_W'(1) << w) - ROW_W'(1);
   endfunction : low_mask

   cfg_type                 cfg_r;
   stat_type                stat;
   logic [15:0]             coll_r;
   mode_type                mode_eff;
   port_req_type [1:0]      req_r;
   logic [1:0]              wr_go_r;
   logic [1:0][ROW_W-1:0]   q_r;
   logic [ROW_W-1:0]        mem [ROWS];
   logic [2:0]              k       [2];
   logic [7:0]              wd      [2];
   logic [7:0]              off     [2];
   logic [ROW_AW-1:0]       row     [2];
   logic [ADDR_W-1:0]       addr_u  [2];
   logic [ROW_W-1:0]        wmask   [2];
   logic [ROW_W-1:0]        rd_row  [2];
   logic [ROW_W-1:0]        rd_sl   [2];
   logic [ROW_W-1:0]        nrow    [2];
   logic [1:0]              wr_en;
   logic [1:0]              rd_en;
   logic [1:0]              rdw;
   logic [1:0]              clr_in_eff;
   logic                    aw_hold_r;
   logic                    w_hold_r;
   logic [AXI_AW-1:0]       aw_addr_r;
   logic [31:0]             w_data_r;
   logic [3:0]              w_strb_r;
   logic                    coll_clr;

   // small block has no true dual-port; the split mode exists in medium only
   always_comb
   begin
      mode_eff = cfg_r.mode;
      if (cfg_r.mode == MODE_TRUE_DUAL && cfg_r.cls == CLASS_SMALL)
         mode_eff = MODE_SIMPLE_DUAL;
      if (cfg_r.mode == MODE_TWO_SINGLE && cfg_r.cls != CLASS_MEDIUM)
         mode_eff = MODE_SINGLE;
   end

   // large block has no input register clear
   assign clr_in_eff = (cfg_r.cls == CLASS_LARGE) ? 2'b00 : clr_in;

   always_ff @(posedge clk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (rst || clr_in_eff[p])
            req_r[p] <= '0;
         else if (ce[p])
            req_r[p] <= req[p];
      end
   end

   // strobe fires the cycle after capture, so address and data are settled
   always_ff @(posedge clk)
   begin
      if (rst)
         wr_go_r <= 2'b00;
      else
         wr_go_r <= ce;
   end

   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         k[p]   = clamp_k(cfg_r.cls, p == 0 ? cfg_r.wk_a : cfg_r.wk_b);
         wd[p]  = width_of(k[p], p == 0 ? cfg_r.par_a : cfg_r.par_b);
         // flow-through: read address taken without its capture stage
         addr_u[p] = (p == 1 && cfg_r.flow && mode_eff == MODE_SIMPLE_DUAL
                      && cfg_r.cls != CLASS_LARGE) ? req[1].addr
                                                   : req_r[p].addr;
         off[p] = 8'(7'(addr_u[p] & ((ADDR_W'(1) << (K_ROW_BITS - k[p]))
                  - ADDR_W'(1))) * wd[p]);
         row[p] = ROW_AW'(addr_u[p] >> (K_ROW_BITS - k[p]))
                  & ROW_AW'(rows_of(cfg_r.cls) - 13'h0001);
         if (mode_eff == MODE_TWO_SINGLE)
            row[p] = (row[p] & HALF_MASK) | (p == 1 ? HALF_BASE : '0);
         wmask[p]  = low_mask(wd[p]) << off[p];
         rd_row[p] = mem[row[p]];
         rd_sl[p]  = (rd_row[p] >> off[p]) & low_mask(wd[p]);
      end
      wr_en[0] = wr_go_r[0] && req_r[0].we && !clr_in_eff[0];
      rd_en[0] = wr_go_r[0] && req_r[0].re && !clr_in_eff[0]
                 && mode_eff != MODE_SIMPLE_DUAL;
      wr_en[1] = wr_go_r[1] && req_r[1].we && !clr_in_eff[1]
                 && (mode_eff == MODE_TRUE_DUAL
                     || mode_eff == MODE_TWO_SINGLE);
      rd_en[1] = ((cfg_r.flow && mode_eff == MODE_SIMPLE_DUAL) ? ce[1]
                  : wr_go_r[1]) && req_r[1].re && !clr_in_eff[1]
                 && mode_eff != MODE_SINGLE;
      // single-port never reads and writes together; the write wins
      if (mode_eff == MODE_SINGLE && wr_en[0])
         rd_en[0] = 1'b0;
      rdw[0] = rd_en[0] && wr_en[1] && row[0] == row[1];
      rdw[1] = rd_en[1] && wr_en[0] && row[1] == row[0];
      nrow[0] = (rd_row[0] & ~wmask[0])
                | ((req_r[0].din & low_mask(wd[0])) << off[0]);
      // port b merges on top of port a when both hit one row
      nrow[1] = (((wr_en[0] && row[0] == row[1]) ? nrow[0] : rd_row[1])
                 & ~wmask[1])
                | ((req_r[1].din & low_mask(wd[1])) << off[1]);
   end

   always_ff @(posedge clk)
   begin
      if (wr_en[0])
         mem[row[0]] <= nrow[0];
      if (wr_en[1])
         mem[row[1]] <= nrow[1];
   end

   // large block has only unknown registered output on a mixed-port collision
   always_ff @(posedge clk)
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (rst || clr_out[p])
            q_r[p] <= '0;
         else if (p == 0 && mode_eff == MODE_SINGLE && wr_en[0])
            q_r[0] <= req_r[0].din & low_mask(wd[0]);
         else if (rd_en[p])
            q_r[p] <= (rdw[p] && !(cfg_r.rdw_old
                       && cfg_r.cls != CLASS_LARGE)) ? RDW_UNKNOWN
                                                     : rd_sl[p];
      end
   end

   always_comb
   begin
      for (int p = 0; p < 2; p++)
      begin
         if (clr_out[p])
            q[p] = '0;
         else if ((p == 0 ? cfg_r.oreg_a : cfg_r.oreg_b)
                  && !(p == 1 && cfg_r.flow
                       && mode_eff == MODE_SIMPLE_DUAL
                       && cfg_r.cls != CLASS_LARGE))
            q[p] = q_r[p];
         else
            q[p] = rd_sl[p];
      end
   end

   // collision counter; a new event in the clearing cycle is kept
   always_ff @(posedge clk)
   begin
      if (rst)
         coll_r <= '0;
      else if (coll_clr)
         coll_r <= 16'((rdw != 2'b00) ? 1 : 0);
      else if (rdw != 2'b00 && coll_r != 16'hFFFF)
         coll_r <= coll_r + 16'h0001;
   end

   assign stat = '{spare: '0, wk_b: k[1], wk_a: k[0], coll: coll_r};

   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign coll_clr = aw_hold_r && w_hold_r && aw_addr_r == STAT_OFF;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_hold_r    <= 1'b0;
         w_hold_r     <= 1'b0;
         aw_addr_r    <= '0;
         w_data_r     <= '0;
         w_strb_r     <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
         cfg_r        <= CFG_RESET;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_hold_r && w_hold_r)
         begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr_r == CFG_OFF || aw_addr_r == STAT_OFF)
                            ? RESP_OKAY : RESP_SLVERR;
            if (aw_addr_r == CFG_OFF)
            begin
               if (w_strb_r[0])
                  cfg_r[7:0] <= w_data_r[7:0];
               if (w_strb_r[1])
                  cfg_r[15:8] <= w_data_r[15:8];
            end
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         if (s_axi_araddr == CFG_OFF)
            s_axi_rdata <= {{(32 - CFG_W){1'b0}}, cfg_r[CFG_W-1:0]};
         else if (s_axi_araddr == STAT_OFF)
            s_axi_rdata <= stat;
         else
         begin
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_SLVERR;
         end
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_out_clear;
      clr_out[0] |-> q[0] == '0 ##1 q_r[0] == '0;
   endproperty
   a_out_clear: assert property (p_out_clear)
      else $error("output clear not seen at once");

   property p_in_clear;
      clr_in[0] && cfg_r.cls != CLASS_LARGE |-> !wr_en[0] ##1 !req_r[0].we;
   endproperty
   a_in_clear: assert property (p_in_clear)
      else $error("input clear did not block write");

   property p_strobe;
      wr_en[0] |-> $past(ce[0]) && req_r[0].we;
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("write strobe without capture");

   property p_single_through;
      mode_eff == MODE_SINGLE && wr_en[0] && !clr_out[0] && cfg_r.oreg_a
      ##1 !clr_out[0] && $stable(cfg_r) |-> q[0] == ($past(req_r[0].din)
      & low_mask(wd[0]));
   endproperty
   a_single_through: assert property (p_single_through)
      else $error("written word not on output after edge");

   property p_simple_dir;
      mode_eff == MODE_SIMPLE_DUAL |-> !wr_en[1] && !rd_en[0];
   endproperty
   a_simple_dir: assert property (p_simple_dir)
      else $error("simple dual-port direction broken");

   property p_no_small_true;
      cfg_r.cls == CLASS_SMALL |-> mode_eff != MODE_TRUE_DUAL;
   endproperty
   a_no_small_true: assert property (p_no_small_true)
      else $error("small block in true dual-port");

   property p_halves;
      mode_eff == MODE_TWO_SINGLE && wr_en[0] |-> row[0][4] == 1'b0
      && (!wr_en[1] || row[1][4]);
   endproperty
   a_halves: assert property (p_halves)
      else $error("split memory crossed halves");

   property p_rows;
      13'(row[0]) < rows_of(cfg_r.cls) && 13'(row[1]) < rows_of(cfg_r.cls);
   endproperty
   a_rows: assert property (p_rows)
      else $error("row beyond class size");

   property p_width;
      cfg_r.cls == CLASS_LARGE |-> k[0] >= K_MIN_LARGE && k[1] >= K_MIN_LARGE;
   endproperty
   a_width: assert property (p_width)
      else $error("large width below minimum");

   property p_oreg_pipe;
      rd_en[1] && !rdw[1] && !clr_out[1] && !cfg_r.flow ##1
      !clr_out[1] && cfg_r.oreg_b && $stable(cfg_r) |-> q[1] == $past(rd_sl[1]);
   endproperty
   a_oreg_pipe: assert property (p_oreg_pipe)
      else $error("registered read data wrong");

   c_two_writes: cover property (wr_en == 2'b11);
   c_collision: cover property (rdw != 2'b00);
   c_flow_read: cover property (cfg_r.flow && rd_en[1] ##1 rd_en[1]);
endmodule : configurable_embedded_ram

/* user_port_model.sv */
// user-logic model that drives one memory port of the ram
`timescale 1ns/1ps
module user_port_model
   import ram_pkg::*;
(
   input  wire logic   clk,
   input  wire logic   lock,
   output port_req_type req,
   output logic        ce
);
   initial
   begin
      ce  = 1'b0;
      req = '0;
   end

   // one request per call; gap idles first, to act as a slow partner
   task automatic op(input logic w, input logic r, input int a,
                     input logic [ROW_W-1:0] d, input int gap);
      repeat (gap) @(posedge clk);
      @(posedge clk);
      ce       <= 1'b1;
      req.we   <= w & ~lock;
      req.re   <= r;
      req.addr <= a[ADDR_W-1:0];
      req.din  <= d;
      @(posedge clk);
      ce  <= 1'b0;
      // released lines must not keep the old value
      req <= ~req;
   endtask : op

   // moves the address only, with no capture pulse
   task automatic look(input int a);
      @(posedge clk);
      req.addr <= a[ADDR_W-1:0];
   endtask : look
endmodule : user_port_model

/* testbench.sv */
// self-checking bench for the configurable embedded ram
`timescale 1ns/1ps
`define CHK(g, e) \
   begin \
      cmp_count++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("ERROR %0t: got %h exp %h", $time, (g), (e)); \
      end \
   end
module testbench
   import ram_pkg::*;
;
   logic                  clk, rst, lock, ce_a, ce_b;
   port_req_type          req_a, req_b;
   logic [1:0]            clr_in, clr_out;
   logic [1:0][ROW_W-1:0] q;
   logic [AXI_AW-1:0]     s_axi_awaddr, s_axi_araddr;
   logic [31:0]           s_axi_wdata, s_axi_rdata, rd;
   logic [3:0]            s_axi_wstrb;
   logic [1:0]            s_axi_bresp, s_axi_rresp, rs;
   logic                  s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic                  s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic                  s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic                  s_axi_rready;
   int                    errors, cmp_count, cyc;
   logic [15:0]           ct [3] = '{16'h03F2, 16'h03F6, 16'h000A};
   logic [5:0]            ck [3] = '{6'h24, 6'h2D, 6'h1B};

   configurable_embedded_ram dut_u (
      .clk, .rst, .ce({ce_b, ce_a}), .req({req_b, req_a}), .clr_in,
      .clr_out, .q, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready);
   user_port_model pa (.clk, .lock, .req(req_a), .ce(ce_a));
   user_port_model pb (.clk, .lock, .req(req_b), .ce(ce_b));

   always #5 clk = ~clk;

   task final_report;
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : final_report

   // hangs are cut short here rather than by each wait
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         errors++;
         $display("ERROR %0t: timeout", $time);
         final_report();
      end
   end

   // ready is sampled mid-cycle, where it is settled, and acted on at the edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
      logic ta, tw, tb;
      tb = 1'b0;
      @(posedge clk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!tb)
      begin
         @(negedge clk);
         ta = s_axi_awvalid & s_axi_awready;
         tw = s_axi_wvalid & s_axi_wready;
         tb = s_axi_bvalid;
         r  = s_axi_bresp;
         @(posedge clk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tb) s_axi_bready <= 1'b0;
      end
   endtask : axw

   task automatic axr(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
      logic ta, tr;
      tr = 1'b0;
      @(posedge clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      while (!tr)
      begin
         @(negedge clk);
         ta = s_axi_arvalid & s_axi_arready;
         tr = s_axi_rvalid;
         d  = s_axi_rdata;
         r  = s_axi_rresp;
         @(posedge clk);
         if (ta) s_axi_arvalid <= 1'b0;
         if (tr) s_axi_rready <= 1'b0;
      end
   endtask : axr

   task automatic cfg(input logic [15:0] v);
      axw(CFG_OFF, {16'h0000, v}, rs);
      `CHK(rs, RESP_OKAY)
   endtask : cfg

   task automatic wr(input int p, input int a, input logic [31:0] d);
      if (p == 0)
         pa.op(1'b1, 1'b0, a, {112'h0, d}, 0);
      else
         pb.op(1'b1, 1'b0, a, {112'h0, d}, 0);
      @(posedge clk);
   endtask : wr

   // registered read: word shows after the edge that follows capture
   task automatic rdq(input int p, input int a, input logic [31:0] e);
      if (p == 0)
         pa.op(1'b0, 1'b1, a, '0, 0);
      else
         pb.op(1'b0, 1'b1, a, '0, 1);
      @(posedge clk);
      #1;
      `CHK(q[p][31:0], e)
   endtask : rdq

   initial
   begin
      clk = 1'b0; rst = 1'b1; lock = 1'b0; clr_in = 2'h0; clr_out = 2'h0;
      s_axi_awaddr = '0; s_axi_araddr = '0; s_axi_wdata = '0;
      s_axi_wstrb = 4'hF; s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0; s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
      errors = 0; cmp_count = 0; cyc = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      #1;
      `CHK(q, '0)
      axr(CFG_OFF, rd, rs);
      `CHK(rd, 32'h0000_7004)
      axr(8'h08, rd, rs);
      `CHK({rs, rd}, {RESP_SLVERR, 32'h0})
      axw(8'h08, 32'h0000_FFFF, rs);
      `CHK(rs, RESP_SLVERR)
      for (int i = 0; i < 3; i++)
      begin
         cfg(ct[i]);
         axr(STAT_OFF, rd, rs);
         `CHK(rd[21:16], ck[i])
      end
      cfg(16'h72D6);
      pa.op(1'b1, 1'b0, 8, {112'h0, 32'h1234_5678}, 0);
      #1;
      `CHK(q[0][31:0], 32'h0)
      @(posedge clk);
      #1;
      `CHK(q[0][31:0], 32'h1234_5678)
      cfg(16'h62D6);
      pa.op(1'b0, 1'b1, 8, '0, 0);
      #1;
      `CHK(q[0][31:0], 32'h1234_5678)
      cfg(16'h72D6);
      rdq(0, 8, 32'h1234_5678);
      @(posedge clk);
      clr_out <= 2'h1;
      #1;
      `CHK(q[0], '0)
      @(posedge clk);
      clr_out <= 2'h0;
      clr_in  <= 2'h1;
      #1;
      `CHK(q[0], '0)
      wr(0, 8, 32'hDEAD_BEEF);
      clr_in  <= 2'h0;
      rdq(0, 8, 32'h1234_5678);
      cfg(16'h73FA);
      clr_in <= 2'h1;
      wr(0, 5, 32'hCAFE_F00D);
      clr_in <= 2'h0;
      rdq(0, 5, 32'hCAFE_F00D);
      lock <= 1'b1;
      wr(0, 5, 32'h1111_1111);
      lock <= 1'b0;
      rdq(0, 5, 32'hCAFE_F00D);
      cfg(16'h72D4);
      fork
         wr(0, 16, 32'hA0A0_0001);
         pb.op(1'b1, 1'b0, 20, {112'h0, 32'hB0B0_0002}, 2);
      join
      @(posedge clk);
      fork
         rdq(0, 20, 32'hB0B0_0002);
         rdq(1, 16, 32'hA0A0_0001);
      join
      cfg(16'h72D5);
      fork
         pa.op(1'b1, 1'b0, 16, {112'h0, 32'hC0C0_0003}, 0);
         pb.op(1'b0, 1'b1, 16, '0, 0);
      join
      @(posedge clk);
      #1;
      `CHK(q[1][31:0], 32'hA0A0_0001)
      cfg(16'h32D5);
      fork
         pa.op(1'b1, 1'b0, 16, {112'h0, 32'hD0D0_0004}, 0);
         pb.op(1'b0, 1'b1, 16, '0, 0);
      join
      @(posedge clk);
      #1;
      `CHK(q[1][31:0], 32'hFFFF_FFFF)
      axr(STAT_OFF, rd, rs);
      `CHK(rd[15:0], 16'h0002)
      axw(STAT_OFF, 32'h0, rs);
      `CHK(rs, RESP_OKAY)
      axr(STAT_OFF, rd, rs);
      `CHK(rd[15:0], 16'h0)
      cfg(16'hD2D5);
      pb.look(16);
      #1;
      `CHK(q[1][31:0], 32'hD0D0_0004)
      pb.look(20);
      #1;
      `CHK(q[1][31:0], 32'hB0B0_0002)
      cfg(16'h72D7);
      wr(0, 4, 32'h0A0A_0A0A);
      wr(1, 4, 32'h0B0B_0B0B);
      rdq(0, 4, 32'h0A0A_0A0A);
      rdq(1, 4, 32'h0B0B_0B0B);
      `CHK({q[1][31:0], q[0][31:0]}, 64'h0B0B_0B0B_0A0A_0A0A)
      cfg(16'h7204);
      for (int i = 0; i < 16; i++)
         wr(0, 384 + i, {31'h0, ((16'hA5C3 >> i) & 16'h1) != 16'h0});
      pb.op(1'b0, 1'b1, 24, '0, 0);
      @(posedge clk);
      #1;
      `CHK(q[1][15:0], 16'hA5C3)
      final_report();
   end
endmodule : testbench
